// file: logic/rhd_control.v
// Run/halt transfer-of-control logic with panel commands and tape input.
//
// How it works
// - Step setting: each run press executes one instruction, then debug.
// - Continuous setting: run press lets the program run until a halt ends it.
// - Halt selector at debug: an executed halt instruction stops the run.
// - Halt selector at pulse: an executed halt instruction is ignored.
// - Halt key during run stops execution and keeps the current PC.
// - Power-up initialises the processor and enters debug unprompted.
// - Init key resets the processor, saves registers, saved PC becomes 0001.
// - Processor registers are saved before debug and shown by read key.
// - Load key replaces a saved register; replaced values are restored on run.
// - Memory load writes, reads the location back and shows stored value.
// - Address/abort key cancels a pending load, leaving the target unchanged.
// - Idle address/abort takes an address, then shows that memory.
// - Memory examine shows a location; repeated presses step addresses.
// - With relay fitted, relay runs the reader one frame at a time.
// - Without relay, accept characters until need is met, then ignore.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "rhd_regs.vh"
module rhd_control #(
   parameter [19:0] DEBOUNCE_CYCLES = `RHD_DEBOUNCE_US * `RHD_CLOCK_MHZ
) (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Operator panel
   input wire runKey,
   input wire haltKey,
   input wire initKey,
   input wire readKey,
   input wire loadKey,
   input wire memExamineKey,
   input wire memLoadKey,
   input wire addrAbortKey,
   input wire digitKey,
   input wire [3:0] digitValue,
   input wire [2:0] regSelect,
   input wire stepSetting,
   input wire haltOpcodeSelector,
   output reg [15:0] displayAddr,
   output reg [15:0] displayData,
   output reg [2:0] displayTag,
   output wire entryPending,
   output wire debugState,
   // Target processor
   output wire cpuReset,
   output wire cpuHold,
   output reg cpuLoad,
   input wire cpuStopped,
   input wire instrDone,
   input wire haltExecuted,
   input wire [15:0] cpuPc,
   input wire [15:0] cpuP1,
   input wire [15:0] cpuP2,
   input wire [15:0] cpuP3,
   input wire [7:0] cpuAc,
   input wire [7:0] cpuEx,
   input wire [7:0] cpuSt,
   output wire [15:0] restorePc,
   output wire [15:0] restoreP1,
   output wire [15:0] restoreP2,
   output wire [15:0] restoreP3,
   output wire [7:0] restoreAc,
   output wire [7:0] restoreEx,
   output wire [7:0] restoreSt,
   // Memory port
   output reg memReq,
   output reg memWrite,
   output reg [15:0] memAddr,
   output reg [7:0] memWdata,
   input wire [7:0] memRdata,
   input wire memAck,
   // Terminal tape input and reader relay
   input wire tapeStrobe,
   input wire [7:0] tapeChar,
   output wire readerRelayDrive
);
   // ****************************************
   // States and commands
   // ****************************************
   localparam [2:0] S_INIT = 3'h0;
   localparam [2:0] S_SAVE = 3'h1;
   localparam [2:0] S_DEBUG = 3'h2;
   localparam [2:0] S_RUN = 3'h3;
   localparam [2:0] S_WRITE = 3'h4;
   localparam [2:0] S_READ = 3'h5;
   localparam [1:0] C_NONE = 2'h0;
   localparam [1:0] C_LOADREG = 2'h1;
   localparam [1:0] C_ADDR = 2'h2;
   localparam [1:0] C_MEMLOAD = 2'h3;
   localparam [2:0] TAG_MEM = 3'h7;
   localparam integer RESET_INT = `RHD_CPU_RESET_CYCLES;
   localparam [6:0] RESET_CYCLES = RESET_INT[6:0];

   // Eight-bit registers take two digits, the rest four.
   function [2:0] digitsFor;
      input [2:0] sel;
      begin
         digitsFor = (sel >= `RHD_SAVED_AC) ? 3'h2 : 3'h4;
      end
   endfunction

   reg [2:0] state;
   reg [1:0] cmd;
   reg [2:0] cmdReg;
   reg [2:0] digits;
   reg [15:0] entry;
   reg [6:0] resetCount;
   reg forcePc;
   reg stepMode;
   reg [15:0] savedReg [0:`RHD_SAVED_COUNT-1];
   reg [15:0] nextAddr;
   reg relayFitted;
   reg [7:0] rxChar;
   reg rxValid;
   reg [7:0] rxNeed;
   reg stepSync1;
   reg stepSync2;
   reg haltSync1;
   reg haltSync2;
   wire [8:0] press;
   wire pRun = press[0];
   wire pHalt = press[1];
   wire pInit = press[2];
   wire pRead = press[3];
   wire pLoad = press[4];
   wire pExam = press[5];
   wire pMemLoad = press[6];
   wire pAbort = press[7];
   wire pDigit = press[8];
   wire [15:0] shifted = {entry[11:0], digitValue};
   wire entryFull = pDigit && (cmd != C_NONE) && (digits == 3'h1);
   wire apbWr = psel && penable && pwrite;
   wire apbRd = psel && penable && !pwrite;
   wire [7:0] ofs = {paddr[7:2], 2'b00};
   wire [2:0] apbIdx = ofs[4:2] - 3'h2;
   wire savedHit = (ofs >= `RHD_SAVED_OFS) && (ofs < `RHD_RXDATA_OFS);
   wire mapped = savedHit || (ofs == `RHD_CTRL_OFS) ||
      (ofs == `RHD_STATUS_OFS) || (ofs == `RHD_RXDATA_OFS) ||
      (ofs == `RHD_RXNEED_OFS);
   wire takeChar = tapeStrobe && (rxNeed != 8'h00);

   // ****************************************
   // Panel key conditioning
   // ****************************************
   rhd_key_filter #(
      .WIDTH(9),
      .CYCLES(DEBOUNCE_CYCLES)
   ) keyFilter (
      .clock(clock),
      .rst_b(rst_b),
      .rawKeys({digitKey, addrAbortKey, memLoadKey, memExamineKey,
         loadKey, readKey, initKey, haltKey, runKey}),
      .keyPress(press)
   );

   // Selector switches are levels, so a plain two-stage capture is enough.
   always @(posedge clock) begin
      if (!rst_b) begin
         stepSync1 <= 1'b0;
         stepSync2 <= 1'b0;
         haltSync1 <= 1'b0;
         haltSync2 <= 1'b0;
      end else begin
         stepSync1 <= stepSetting;
         stepSync2 <= stepSync1;
         haltSync1 <= haltOpcodeSelector;
         haltSync2 <= haltSync1;
      end
   end

   // ****************************************
   // Transfer of control and panel commands
   // ****************************************
   assign cpuReset = (state == S_INIT);
   assign cpuHold = (state != S_RUN);
   assign debugState = (state == S_DEBUG);
   assign entryPending = (cmd != C_NONE);
   assign restorePc = savedReg[0];
   assign restoreP1 = savedReg[1];
   assign restoreP2 = savedReg[2];
   assign restoreP3 = savedReg[3];
   assign restoreAc = savedReg[4][7:0];
   assign restoreEx = savedReg[5][7:0];
   assign restoreSt = savedReg[6][7:0];

   integer k;
   always @(posedge clock) begin
      if (!rst_b) begin
         state <= S_INIT;
         cmd <= C_NONE;
         cmdReg <= 3'h0;
         digits <= 3'h0;
         entry <= 16'h0000;
         resetCount <= 7'h00;
         forcePc <= 1'b1;
         stepMode <= 1'b0;
         cpuLoad <= 1'b0;
         memReq <= 1'b0;
         memWrite <= 1'b0;
         memAddr <= 16'h0000;
         memWdata <= 8'h00;
         nextAddr <= 16'h0000;
         displayAddr <= 16'h0000;
         displayData <= 16'h0000;
         displayTag <= 3'h0;
         for (k = 0; k < `RHD_SAVED_COUNT; k = k + 1) begin
            savedReg[k] <= 16'h0000;
         end
      end else begin
         cpuLoad <= 1'b0;
         case (state)
            S_INIT: begin
               if (resetCount >= RESET_CYCLES - 7'h01) begin
                  resetCount <= 7'h00;
                  state <= S_SAVE;
               end else begin
                  resetCount <= resetCount + 7'h01;
               end
            end
            S_SAVE: begin
               if (cpuStopped) begin
                  savedReg[0] <= forcePc ? `RHD_INIT_PC : cpuPc;
                  savedReg[1] <= cpuP1;
                  savedReg[2] <= cpuP2;
                  savedReg[3] <= cpuP3;
                  savedReg[4] <= {8'h00, cpuAc};
                  savedReg[5] <= {8'h00, cpuEx};
                  savedReg[6] <= {8'h00, cpuSt};
                  displayData <= forcePc ? `RHD_INIT_PC : cpuPc;
                  displayTag <= `RHD_SAVED_PC;
                  forcePc <= 1'b0;
                  state <= S_DEBUG;
               end
            end
            S_RUN: begin
               if (pHalt) begin
                  state <= S_SAVE;
               end else if (haltExecuted && !haltSync2) begin
                  state <= S_SAVE;
               end else if (stepMode && instrDone) begin
                  state <= S_SAVE;
               end
            end
            S_WRITE: begin
               if (memAck) begin
                  memWrite <= 1'b0;
                  state <= S_READ;
               end
            end
            S_READ: begin
               if (memAck) begin
                  memReq <= 1'b0;
                  displayAddr <= memAddr;
                  displayData <= {8'h00, memRdata};
                  displayTag <= TAG_MEM;
                  nextAddr <= memAddr + 16'h0001;
                  state <= S_DEBUG;
               end else begin
                  memReq <= 1'b1;
               end
            end
            S_DEBUG: begin
               if (apbWr && savedHit) begin
                  savedReg[apbIdx] <= pwdata[15:0];
               end
               if (pRun) begin
                  cmd <= C_NONE;
                  cpuLoad <= 1'b1;
                  stepMode <= stepSync2;
                  state <= S_RUN;
               end else if (pAbort) begin
                  if (cmd != C_NONE) begin
                     cmd <= C_NONE;
                  end else begin
                     cmd <= C_ADDR;
                     digits <= 3'h4;
                  end
               end else if (pLoad) begin
                  cmd <= C_LOADREG;
                  cmdReg <= regSelect;
                  digits <= digitsFor(regSelect);
                  entry <= 16'h0000;
               end else if (pMemLoad) begin
                  cmd <= C_MEMLOAD;
                  digits <= 3'h2;
                  entry <= 16'h0000;
               end else if (pRead && cmd == C_NONE) begin
                  displayTag <= regSelect;
                  displayData <= savedReg[regSelect];
               end else if (pExam && cmd == C_NONE) begin
                  memAddr <= nextAddr;
                  state <= S_READ;
               end else if (pDigit && cmd != C_NONE) begin
                  entry <= shifted;
                  digits <= digits - 3'h1;
                  if (entryFull) begin
                     cmd <= C_NONE;
                     case (cmd)
                        C_LOADREG: begin
                           savedReg[cmdReg] <= shifted;
                           displayTag <= cmdReg;
                           displayData <= shifted;
                        end
                        C_ADDR: begin
                           memAddr <= shifted;
                           state <= S_READ;
                        end
                        default: begin
                           memAddr <= displayAddr;
                           memWdata <= shifted[7:0];
                           memWrite <= 1'b1;
                           memReq <= 1'b1;
                           state <= S_WRITE;
                        end
                     endcase
                  end
               end
            end
            default: begin
               state <= S_SAVE;
            end
         endcase
         // Init wins over any other next state, command or memory request, in any state.
         if (pInit) begin
            state <= S_INIT;
            forcePc <= 1'b1;
            resetCount <= 7'h00;
            cmd <= C_NONE;
            memReq <= 1'b0;
            memWrite <= 1'b0;
         end
      end
   end

   // ****************************************
   // Tape input and reader relay
   // ****************************************
   // Only one frame is held, so the relay stops the reader until it is read.
   assign readerRelayDrive = relayFitted && (rxNeed != 8'h00) &&
      !rxValid;

   always @(posedge clock) begin
      if (!rst_b) begin
         relayFitted <= 1'b0;
         rxChar <= 8'h00;
         rxValid <= 1'b0;
         rxNeed <= 8'h00;
      end else begin
         if (apbWr && ofs == `RHD_CTRL_OFS) begin
            relayFitted <= pwdata[`RHD_CTRL_RELAY_BIT];
         end
         if (apbRd && ofs == `RHD_RXDATA_OFS) begin
            rxValid <= 1'b0;
         end
         if (apbWr && ofs == `RHD_RXNEED_OFS) begin
            rxNeed <= pwdata[7:0];
         end else if (takeChar) begin
            rxNeed <= rxNeed - 8'h01;
         end
         // A new character beats a read-clear in the same cycle.
         if (takeChar) begin
            rxChar <= tapeChar;
            rxValid <= 1'b1;
         end
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Read data is fetched in the setup cycle, so access needs no wait.
   always @(posedge clock) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         if (savedHit) begin
            prdata <= {16'h0000, savedReg[apbIdx]};
         end else if (ofs == `RHD_CTRL_OFS) begin
            prdata <= {31'h00000000, relayFitted};
         end else if (ofs == `RHD_STATUS_OFS) begin
            prdata <= {24'h000000, readerRelayDrive, stepMode, cmd,
               1'b0, state};
         end else if (ofs == `RHD_RXDATA_OFS) begin
            prdata <= {23'h000000, rxValid, rxChar};
         end else if (ofs == `RHD_RXNEED_OFS) begin
            prdata <= {24'h000000, rxNeed};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
endmodule

// file: logic/rhd_regs.vh
// Constants for the run/halt debug control block.
`ifndef RHD_REGS_VH
`define RHD_REGS_VH

// ****************************************
// Register byte offsets on APB
// ****************************************
`define RHD_CTRL_OFS 8'h00
`define RHD_STATUS_OFS 8'h04
`define RHD_SAVED_OFS 8'h08
`define RHD_RXDATA_OFS 8'h24
`define RHD_RXNEED_OFS 8'h28

// ****************************************
// Field positions
// ****************************************
`define RHD_CTRL_RELAY_BIT 0
`define RHD_RXDATA_VALID_BIT 8
`define RHD_SAVED_COUNT 7
`define RHD_SAVED_PC 3'h0
`define RHD_SAVED_AC 3'h4

// ****************************************
// Reset values and timing
// ****************************************
`define RHD_INIT_PC 16'h0001
`define RHD_CLOCK_MHZ 100
`define RHD_DEBOUNCE_US 5000
`define RHD_CPU_RESET_NS 1000
`define RHD_CPU_RESET_CYCLES (`RHD_CPU_RESET_NS * `RHD_CLOCK_MHZ / 1000)
`define RHD_DEBOUNCE_W 20

`endif

// file: logic/rhd_key_filter.v
// Synchroniser, debouncer and press detector for panel keys.
`timescale 1ns/100ps
module rhd_key_filter #(
   parameter WIDTH = 9,
   parameter [19:0] CYCLES = 20'h7a120
) (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Raw keys and one-cycle press events
   input wire [WIDTH-1:0] rawKeys,
   output wire [WIDTH-1:0] keyPress
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : key
         reg sync1;
         reg sync2;
         reg stable;
         reg pressed;
         reg [19:0] count;
         // A key must hold a new level for the whole window to count.
         always @(posedge clock) begin
            if (!rst_b) begin
               sync1 <= 1'b0;
               sync2 <= 1'b0;
               stable <= 1'b0;
               pressed <= 1'b0;
               count <= 20'h00000;
            end else begin
               sync1 <= rawKeys[i];
               sync2 <= sync1;
               pressed <= 1'b0;
               if (sync2 == stable) begin
                  count <= 20'h00000;
               end else if (count >= CYCLES - 20'h00001) begin
                  stable <= sync2;
                  pressed <= sync2;
                  count <= 20'h00000;
               end else begin
                  count <= count + 20'h00001;
               end
            end
         end
         assign keyPress[i] = pressed;
      end
   endgenerate
endmodule

// file: tb/rhd_control_properties.sv
// Concurrent checks on the ports of the run/halt debug control block.
`timescale 1ns/100ps
module rhd_checker (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Panel and processor side
   input wire haltOpcodeSelector,
   input wire debugState,
   input wire cpuReset,
   input wire cpuHold,
   input wire cpuLoad,
   input wire haltExecuted,
   input wire [15:0] displayData,
   input wire [2:0] displayTag,
   // Memory port
   input wire memReq,
   input wire memWrite,
   input wire [15:0] memAddr,
   input wire [7:0] memRdata,
   input wire memAck
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   hold_in_debug_a: assert property (debugState |-> cpuHold)
      else $error("processor not held in debug");
   reset_hold_a: assert property ($rose(rst_b) |-> cpuReset [*8])
      else $error("processor reset not held after release");
   reset_stop_a: assert property (cpuReset |-> cpuHold && !debugState)
      else $error("processor reset outside init");
   load_pulse_a: assert property (cpuLoad |-> !cpuHold ##1 !cpuLoad)
      else $error("restore pulse malformed");
   halt_stop_a: assert property (
      !cpuHold && haltExecuted && !haltOpcodeSelector &&
      !$past(haltOpcodeSelector, 3) |-> ##[1:4] cpuHold)
      else $error("halt instruction did not stop the run");
   mem_hold_a: assert property (
      memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
      else $error("memory request changed before acknowledge");
   write_read_a: assert property (
      memReq && memWrite && memAck |=> memReq && !memWrite)
      else $error("no read-back after memory write");
   read_back_a: assert property (
      $fell(memReq) |-> displayData[7:0] == $past(memRdata) &&
      displayTag == 3'h7)
      else $error("stored memory value not shown");
endmodule

bind rhd_control rhd_checker i_chk (.clock, .rst_b, .haltOpcodeSelector,
   .debugState, .cpuReset, .cpuHold, .cpuLoad, .haltExecuted, .displayData,
   .displayTag, .memReq, .memWrite, .memAddr, .memRdata, .memAck);

// file: tb/rhd_cpu_model.sv
// Behavioural target processor and byte memory for the bench.
`timescale 1ns/100ps
module rhd_cpu_model #(
   parameter [15:0] ROM_BASE = 16'h7800
) (
   // Clock
   input wire clock,
   // Control from the block
   input wire cpuReset,
   input wire cpuHold,
   input wire cpuLoad,
   input wire [15:0] restorePc,
   input wire [15:0] haltPc,
   output logic cpuStopped = 1'b0,
   output logic instrDone = 1'b0,
   output logic haltExecuted = 1'b0,
   output logic [15:0] cpuPc = 16'h0000,
   // Memory port
   input wire memReq,
   input wire memWrite,
   input wire [15:0] memAddr,
   input wire [7:0] memWdata,
   output wire [7:0] memRdata,
   output logic memAck = 1'b0
);
   logic [7:0] mem [0:65535];
   logic [7:0] lastData = 8'h00;
   logic [2:0] tick = 3'h0;
   logic [1:0] stopCnt = 2'h0;
   int ackWait = 0;
   initial begin
      foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
   end
   // Stopping takes a few cycles, as the processor finishes its cycle.
   always @(posedge clock) begin
      instrDone <= 1'b0;
      haltExecuted <= 1'b0;
      memAck <= 1'b0;
      if (!cpuHold || cpuReset) stopCnt <= 2'h0;
      else if (stopCnt != 2'h3) stopCnt <= stopCnt + 2'h1;
      cpuStopped <= stopCnt == 2'h3 && cpuHold;
      if (cpuReset) begin
         cpuPc <= 16'h0000;
         tick <= 3'h0;
      end else if (cpuLoad) begin
         cpuPc <= restorePc;
         tick <= 3'h0;
      end else if (!cpuHold) begin
         tick <= tick + 3'h1;
         if (tick == 3'h5) begin
            tick <= 3'h0;
            cpuPc <= cpuPc + 16'h0001;
            instrDone <= 1'b1;
            haltExecuted <= cpuPc == haltPc;
         end
      end
      if (memReq && !memAck) begin
         if (ackWait == 0) begin
            memAck <= 1'b1;
            lastData <= mem[memAddr];
            if (memWrite && memAddr < ROM_BASE) mem[memAddr] <= memWdata;
            ackWait <= int'($urandom % 32'h4);
         end else
            ackWait <= ackWait - 1;
      end
   end
   // A released data bus must never look like the last valid byte.
   assign memRdata = memAck ? lastData : ~lastData;
endmodule

// file: tb/tb.sv
// Self-checking bench for the run/halt debug control block.
`timescale 1ns/100ps
module tb;
   localparam int kRun = 0, kHalt = 1, kInit = 2, kRead = 3, kLoad = 4;
   localparam int kExam = 5, kMLoad = 6, kAbort = 7, kDigit = 8;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [8:0] keys = 9'h000;
   logic [3:0] digitValue = 4'h0;
   logic [2:0] regSelect = 3'h0;
   logic stepSetting = 1'b1, haltOpcodeSelector = 1'b1, tapeStrobe = 1'b0;
   logic [7:0] tapeChar = 8'h00, d;
   logic [15:0] haltPc = 16'hffff, a;
   logic [15:0] regIn [1:6];
   logic [15:0] saved [0:6];
   logic [7:0] memW [logic [15:0]];
   wire [31:0] prdata;
   wire pready, pslverr, debugState, cpuReset, cpuHold, cpuLoad, entryPending;
   wire cpuStopped, instrDone, haltExecuted, memReq, memWrite, memAck;
   wire readerRelayDrive;
   wire [15:0] displayAddr, displayData, cpuPc, restorePc, memAddr;
   wire [2:0] displayTag;
   wire [7:0] memWdata, memRdata;
   wire [15:0] rP1, rP2, rP3;
   wire [7:0] rAc, rEx, rSt;
   int mismatches = 0, numChecks = 0;
   logic [31:0] rd;
   logic err;

   always #5 clock = ~clock;

   rhd_control #(.DEBOUNCE_CYCLES(20'h4)) i_dut (.clock, .rst_b, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .runKey(keys[0]), .haltKey(keys[1]), .initKey(keys[2]),
      .readKey(keys[3]), .loadKey(keys[4]), .memExamineKey(keys[5]),
      .memLoadKey(keys[6]), .addrAbortKey(keys[7]), .digitKey(keys[8]),
      .digitValue, .regSelect, .stepSetting, .haltOpcodeSelector,
      .displayAddr, .displayData, .displayTag, .entryPending, .debugState,
      .cpuReset, .cpuHold, .cpuLoad, .cpuStopped, .instrDone, .haltExecuted,
      .cpuPc, .cpuP1(regIn[1]), .cpuP2(regIn[2]), .cpuP3(regIn[3]),
      .cpuAc(regIn[4][7:0]), .cpuEx(regIn[5][7:0]), .cpuSt(regIn[6][7:0]),
      .restorePc, .restoreP1(rP1), .restoreP2(rP2), .restoreP3(rP3),
      .restoreAc(rAc), .restoreEx(rEx), .restoreSt(rSt), .memReq, .memWrite,
      .memAddr, .memWdata, .memRdata, .memAck, .tapeStrobe, .tapeChar,
      .readerRelayDrive);
   rhd_cpu_model i_cpu (.clock, .cpuReset, .cpuHold, .cpuLoad, .restorePc,
      .haltPc, .cpuStopped, .instrDone, .haltExecuted, .cpuPc, .memReq,
      .memWrite, .memAddr, .memWdata, .memRdata, .memAck);

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string what, input logic [47:0] seen, exp);
      numChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic endSim;
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [7:0] memExp(input logic [15:0] x);
      return memW.exists(x) ? memW[x] : x[7:0] ^ 8'h5a;
   endfunction
   task automatic apb(input logic wr, input logic [7:0] ad,
      input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   // Held well past the debounce span so one press makes one event.
   task automatic press(input int k);
      keys[k] <= 1'b1;
      repeat (12) @(posedge clock);
      keys[k] <= 1'b0;
      repeat (12) @(posedge clock);
   endtask
   task automatic enter(input int n, input logic [15:0] v);
      for (int i = n - 1; i >= 0; i--) begin
         digitValue <= v[4*i +: 4];
         press(kDigit);
      end
   endtask
   task automatic waitDebug(input string what);
      int n;
      n = 0;
      while (debugState !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk(what, {15'h0, debugState}, 16'h1);
   endtask
   task automatic loadReg(input int s, input logic [15:0] v);
      regSelect <= 3'(s);
      press(kLoad);
      enter(s < 4 ? 4 : 2, v);
      saved[s] = v;
   endtask
   task automatic readReg(input int s);
      regSelect <= 3'(s);
      press(kRead);
      chk("read tag", {13'h0, displayTag}, 16'(s));
      chk("read value", s < 4 ? displayData : {8'h0, displayData[7:0]},
         saved[s]);
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      endSim();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      void'($urandom(32'hf8c7));
      for (int i = 1; i < 7; i++) regIn[i] = 16'($urandom);
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      waitDebug("power-up debug");
      saved[0] = 16'h0001;
      for (int i = 1; i < 7; i++)
         saved[i] = i < 4 ? regIn[i] : regIn[i] & 16'hff;
      chk("saved pc", restorePc, 16'h0001);
      chk("pc shown", displayData, 16'h0001);
      for (int s = 0; s < 7; s++) readReg(s);
      $display("test power-up done");
      for (int s = 0; s < 7; s++) begin
         loadReg(s, s < 4 ? 16'($urandom) : {8'h00, 8'($urandom)});
         apb(1'b0, 8'(8 + 4 * s), 0);
         chk("saved reg", rd[15:0], saved[s]);
      end
      for (int s = 0; s < 7; s++) readReg(s);
      chk("restore p", {rP1, rP2, rP3}, {saved[1], saved[2], saved[3]});
      chk("restore b", {rAc, rEx, rSt},
         {saved[4][7:0], saved[5][7:0], saved[6][7:0]});
      regSelect <= 3'h0;
      press(kLoad);
      enter(2, 16'h00ab);
      chk("entry open", {15'h0, entryPending}, 16'h1);
      press(kAbort);
      chk("entry closed", {15'h0, entryPending}, 16'h0);
      chk("pc kept", restorePc, saved[0]);
      $display("test register load done");
      for (int i = 0; i < 3; i++) begin
         a = i == 2 ? 16'($urandom % 32'h7000) : 16'h77fe + 16'(i);
         press(kAbort);
         enter(4, a);
         chk("addr shown", displayAddr, a);
         chk("mem shown", {8'h0, displayData[7:0]}, {8'h0, memExp(a)});
         a = a + 16'h1;
         press(kExam);
         chk("next addr", displayAddr, a);
         chk("next mem", {8'h0, displayData[7:0]}, {8'h0, memExp(a)});
         d = 8'($urandom);
         press(kMLoad);
         enter(2, {8'h0, d});
         if (a < 16'h7800) memW[a] = d;
         chk("read back", {8'h0, displayData[7:0]}, {8'h0, memExp(a)});
      end
      $display("test memory done");
      loadReg(0, 16'h1000);
      for (int k = 1; k < 3; k++) begin
         press(kRun);
         waitDebug("step stop");
         chk("one step", restorePc, 16'h1000 + 16'(k));
      end
      haltPc <= 16'h1004;
      stepSetting <= 1'b0;
      press(kRun);
      repeat (60) @(posedge clock);
      chk("still running", {15'h0, debugState}, 16'h0);
      press(kHalt);
      waitDebug("halt key stop");
      chk("pc kept", restorePc, cpuPc);
      loadReg(0, 16'h1000);
      haltOpcodeSelector <= 1'b0;
      press(kRun);
      waitDebug("halt stop");
      chk("halt pc", restorePc, 16'h1005);
      press(kInit);
      waitDebug("init stop");
      chk("init pc", restorePc, 16'h0001);
      $display("test run control done");
      apb(1'b1, 8'h00, 1);
      apb(1'b1, 8'h28, 2);
      chk("relay on", {15'h0, readerRelayDrive}, 16'h1);
      for (int i = 0; i < 3; i++) begin
         d = 8'($urandom);
         tapeChar <= d;
         tapeStrobe <= 1'b1;
         @(posedge clock);
         tapeStrobe <= 1'b0;
         @(posedge clock);
         chk("relay held", {15'h0, readerRelayDrive}, 16'h0);
         apb(1'b0, 8'h24, 0);
         chk("rx valid", {15'h0, rd[8]}, i < 2 ? 16'h1 : 16'h0);
         if (i < 2) chk("rx char", {8'h0, rd[7:0]}, {8'h0, d});
         chk("relay again", {15'h0, readerRelayDrive}, 16'(i == 0));
      end
      apb(1'b0, 8'h40, 0);
      chk("unmapped err", {15'h0, err}, 16'h1);
      chk("unmapped data", rd[15:0], 16'h0);
      $display("test tape done");
      endSim();
   end
endmodule
